/* File: shared/ltmc_defs.svh */
// Timing constants for the LIN transceiver mode controller
`ifndef LTMC_DEFS_SVH
`define LTMC_DEFS_SVH
`define LTMC_CLK_NS 25
// Times in ns
`define LTMC_FIRST_DOM_NS 50000
`define LTMC_FLAG_NS 4000
`define LTMC_TOGGLE_STEP_NS 12500
`define LTMC_TOGGLE_MAX_NS 45000
`define LTMC_SLEEP_DLY_NS 70000
`define LTMC_WAKE_FILT_NS 48000
`define LTMC_BUS_WAKE_NS 70000
`define LTMC_EN_DEGL_NS 10000
`define LTMC_TXD_DOM_NS 5000000
// Cycle counts: least times round up, longest round down
`define LTMC_FIRST_DOM_CYC (`LTMC_FIRST_DOM_NS / `LTMC_CLK_NS)
`define LTMC_FLAG_CYC (`LTMC_FLAG_NS / `LTMC_CLK_NS)
`define LTMC_TOGGLE_STEP_CYC \
   ((`LTMC_TOGGLE_STEP_NS + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
`define LTMC_TOGGLE_MAX_CYC (`LTMC_TOGGLE_MAX_NS / `LTMC_CLK_NS)
`define LTMC_SLEEP_DLY_CYC \
   ((`LTMC_SLEEP_DLY_NS + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
`define LTMC_WAKE_FILT_CYC \
   ((`LTMC_WAKE_FILT_NS + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
`define LTMC_BUS_WAKE_CYC \
   ((`LTMC_BUS_WAKE_NS + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
`define LTMC_EN_DEGL_CYC \
   ((`LTMC_EN_DEGL_NS + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
`define LTMC_TXD_DOM_CYC (`LTMC_TXD_DOM_NS / `LTMC_CLK_NS)
`endif

/* File: shared/ltmc_pkg.sv */
// Types for the LIN transceiver mode controller
package ltmc_pkg;
   typedef enum logic [1:0] {
      LTMC_AWAKE  = 2'b00,
      LTMC_NORMAL = 2'b01,
      LTMC_PREP   = 2'b10,
      LTMC_SLEEP  = 2'b11
   } ltmc_mode_t;

   typedef enum logic [2:0] {
      LTMC_TG_IDLE = 3'b000,
      LTMC_TG_HI1  = 3'b001,
      LTMC_TG_LO   = 3'b010,
      LTMC_TG_HI2  = 3'b011,
      LTMC_TG_FAIL = 3'b100
   } ltmc_tog_t;

   // Fault inputs travelling together
   typedef struct packed {
      logic undervolt;
      logic bus_drv_hot;
      logic inh_drv_hot;
   } ltmc_fault_t;

   // Bus driver and receive pin state
   typedef struct packed {
      logic bus_pull_low;
      logic rx_out;
      logic rx_oe_n;
   } ltmc_pins_t;
endpackage : ltmc_pkg

/* File: src/ltmc_fifo.sv */
// Valid/ready FIFO for the received bus samples
`timescale 1ns/10ps
module ltmc_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 32
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign push = in_valid_i && in_ready_o && ce_i;
   assign pop = out_valid_o && out_ready_i && ce_i;
   assign out_data_o = mem[rp_reg];

   always_comb begin
      wp_next = push ? wp_reg + AW'(1) : wp_reg;
      rp_next = pop ? rp_reg + AW'(1) : rp_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
      end
      if (push) begin
         mem[wp_reg] <= in_data_i;
      end
   end
endmodule : ltmc_fifo

/* File: src/ltmc_ctrl.sv */
// LIN transceiver mode, transmit, receive and wake control
// Notes on behaviour
// - Supply undervoltage blocks transmit and holds the bus recessive.
// - Bus transmit and receive stay inactive outside Normal mode.
// - No dominant drive until first-dominant delay after Normal entry.
// - Receiver path to receive pin enabled at once on Normal entry.
// - Bus driver overheat: tx and rx recessive, inhibit off, auto recover.
// - Fast rate entry: receive pin low for flag time after enable rise.
// - Second toggle in fast rate exits; receive pin stays high.
// - In Normal, transmit low pulls bus low, high releases it.
// - An unconnected transmit input reads as recessive.
// - Transmit dominant beyond timeout forces driver recessive.
// - Receive pin high when bus recessive, low when dominant.
// - Sleep: receive pin high impedance; driven low after a wake-up.
// - Enable high selects Normal with both paths running.
// - Enable low past sleep delay enters Sleep if wake input steady.
// - Inhibit output off in Sleep.
// - Inhibit overheat: inhibit off, bus tx and rx recessive.
// - Wake level captured on Sleep entry; opposite level wakes.
// - Wake change during sleep delay leads to Awake, not Sleep; here only if it persists the filter time before the delay ends.
// - Wake pulses shorter than the filter time are ignored.
// - First-dominant delay at most 80 us, typically 50 us.
// - Fast rate flag lasts between 1.875 and 6.25 us.
// - Toggle steps 12.5 us each, whole sequence at most 45 us.
// - Bus wake needs dominant longer than bus wake filter, then recessive.
`timescale 1ns/10ps
`include "ltmc_defs.svh"
module ltmc_ctrl #(
   parameter int TXD_DOM_CYC = `LTMC_TXD_DOM_CYC,
   parameter int FIFO_DEPTH = 32
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Controller pins
   input wire logic txd_i,
   input wire logic txd_conn_i,
   input wire logic en_i,
   output logic rxd_o,
   output logic rxd_oe_n_o,
   // Bus pin and wake input
   input wire logic bus_i,
   output logic bus_o,
   output logic bus_oe_n_o,
   input wire logic wake_i,
   // Faults and supply control
   input wire ltmc_pkg::ltmc_fault_t fault_i,
   output logic regulator_inhibit_out_o,
   output logic fast_rate_o,
   output ltmc_pkg::ltmc_mode_t mode_o,
   // Received bus samples
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic rx_data_o,
   output logic rx_overrun_o
);
   localparam int CW = 24;
   ////////////////////////////////////////////////////////////////////////
   // Three-stage input sampling
   logic [2:0] txd_s, en_s, bus_s, wake_s, conn_s;
   logic txd_f, en_f, bus_f, wake_f;
   ltmc_pkg::ltmc_fault_t flt_s1, flt_s2, flt_s3, flt;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         txd_s <= 3'h7;
         en_s <= 3'h0;
         bus_s <= 3'h7;
         wake_s <= 3'h0;
         conn_s <= 3'h0;
         flt_s1 <= '0;
         flt_s2 <= '0;
         flt_s3 <= '0;
      end else if (ce_i) begin
         txd_s <= {txd_s[1:0], txd_i};
         en_s <= {en_s[1:0], en_i};
         bus_s <= {bus_s[1:0], bus_i};
         wake_s <= {wake_s[1:0], wake_i};
         conn_s <= {conn_s[1:0], txd_conn_i};
         flt_s1 <= fault_i;
         flt_s2 <= flt_s1;
         flt_s3 <= flt_s2;
      end
   end
   // Level accepted only when stages two and three agree; faults follow stage three
   function automatic logic agree(input logic [2:0] s, input logic old);
      agree = (s[1] == s[2]) ? s[1] : old;
   endfunction : agree
   logic txd_f_reg, en_f_reg, bus_f_reg, wake_f_reg;
   always_comb begin
      txd_f = agree(txd_s, txd_f_reg) | ~agree(conn_s, 1'b0);
      en_f = agree(en_s, en_f_reg);
      bus_f = agree(bus_s, bus_f_reg);
      wake_f = agree(wake_s, wake_f_reg);
      flt = (flt_s2 == flt_s3) ? flt_s2 : flt_s3;
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         txd_f_reg <= 1'b1;
         en_f_reg <= 1'b0;
         bus_f_reg <= 1'b1;
         wake_f_reg <= 1'b0;
      end else if (ce_i) begin
         txd_f_reg <= txd_f;
         en_f_reg <= en_f;
         bus_f_reg <= bus_f;
         wake_f_reg <= wake_f;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Mode machine
   ltmc_pkg::ltmc_mode_t mode_reg, mode_next;
   logic [CW-1:0] en_cnt_reg, en_cnt_next, sd_cnt_reg, sd_cnt_next;
   logic [CW-1:0] wf_cnt_reg, wf_cnt_next, bw_cnt_reg, bw_cnt_next;
   logic wref_reg, wref_next, wchg_reg, wchg_next, wok_reg, wok_next;
   logic wake_ev_reg, wake_ev_next;
   logic wake_filt;
   // Wake deglitch: a changed level must persist the filter time
   assign wake_filt = wf_cnt_reg >= CW'(`LTMC_WAKE_FILT_CYC);
   always_comb begin
      mode_next = mode_reg;
      en_cnt_next = en_f ? en_cnt_reg + CW'(1) : '0;
      if (en_f && en_cnt_reg == '1) en_cnt_next = en_cnt_reg;
      sd_cnt_next = '0;
      wf_cnt_next = (wake_f != wref_reg) ? wf_cnt_reg + CW'(1) : '0;
      // Saturate only while the level differs, else the filter latches on
      if (wake_filt && wake_f != wref_reg) wf_cnt_next = wf_cnt_reg;
      bw_cnt_next = !bus_f ? bw_cnt_reg + CW'(1) : '0;
      if (!bus_f && bw_cnt_reg == '1) bw_cnt_next = bw_cnt_reg;
      wref_next = wref_reg;
      wchg_next = wchg_reg;
      wok_next = wok_reg;
      wake_ev_next = wake_ev_reg;
      unique case (mode_reg)
         ltmc_pkg::LTMC_AWAKE: begin
            wref_next = wake_f;
            if (en_cnt_reg >= CW'(`LTMC_EN_DEGL_CYC)) begin
               mode_next = ltmc_pkg::LTMC_NORMAL;
               wake_ev_next = 1'b0;
            end
         end
         ltmc_pkg::LTMC_NORMAL: begin
            wref_next = wake_f;
            if (!en_f) begin
               mode_next = ltmc_pkg::LTMC_PREP;
               wchg_next = 1'b0;
            end
         end
         ltmc_pkg::LTMC_PREP: begin
            sd_cnt_next = sd_cnt_reg + CW'(1);
            if (wake_f != wref_reg) wchg_next = 1'b1;
            if (en_cnt_reg >= CW'(`LTMC_EN_DEGL_CYC)) begin
               mode_next = ltmc_pkg::LTMC_NORMAL;
            end else if (wchg_reg && wake_filt) begin
               mode_next = ltmc_pkg::LTMC_AWAKE;
               wake_ev_next = 1'b1;
            end else if (sd_cnt_reg >= CW'(`LTMC_SLEEP_DLY_CYC)) begin
               mode_next = ltmc_pkg::LTMC_SLEEP;
               wref_next = wake_f;
               wok_next = 1'b0;
               wake_ev_next = 1'b0;
            end
         end
         ltmc_pkg::LTMC_SLEEP: begin
            if (bw_cnt_reg >= CW'(`LTMC_BUS_WAKE_CYC)) wok_next = 1'b1;
            if (wake_filt) begin
               mode_next = ltmc_pkg::LTMC_AWAKE;
               wake_ev_next = 1'b1;
            end else if (wok_reg && bus_f) begin
               mode_next = ltmc_pkg::LTMC_AWAKE;
               wake_ev_next = 1'b1;
            end else if (en_cnt_reg >= CW'(`LTMC_EN_DEGL_CYC)) begin
               mode_next = ltmc_pkg::LTMC_NORMAL;
            end
         end
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mode_reg <= ltmc_pkg::LTMC_AWAKE;
         en_cnt_reg <= '0;
         sd_cnt_reg <= '0;
         wf_cnt_reg <= '0;
         bw_cnt_reg <= '0;
         wref_reg <= 1'b0;
         wchg_reg <= 1'b0;
         wok_reg <= 1'b0;
         wake_ev_reg <= 1'b1;
      end else if (ce_i) begin
         mode_reg <= mode_next;
         en_cnt_reg <= en_cnt_next;
         sd_cnt_reg <= sd_cnt_next;
         wf_cnt_reg <= wf_cnt_next;
         bw_cnt_reg <= bw_cnt_next;
         wref_reg <= wref_next;
         wchg_reg <= wchg_next;
         wok_reg <= wok_next;
         wake_ev_reg <= wake_ev_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Toggle sequence, first-dominant and dominant timeout
   ltmc_pkg::ltmc_tog_t tg_reg, tg_next;
   logic [CW-1:0] tg_tot_reg, tg_tot_next, tg_st_reg, tg_st_next;
   logic [CW-1:0] fd_cnt_reg, fd_cnt_next, dom_cnt_reg, dom_cnt_next;
   logic [CW-1:0] flag_cnt_reg, flag_cnt_next;
   logic fast_reg, fast_next, in_norm, en_rise, step_ok, tx_ok;
   assign in_norm = (mode_reg == ltmc_pkg::LTMC_NORMAL);
   assign en_rise = en_f && !en_f_reg;
   assign step_ok = tg_st_reg >= CW'(`LTMC_TOGGLE_STEP_CYC);
   always_comb begin
      tg_next = tg_reg;
      tg_tot_next = tg_tot_reg + CW'(1);
      tg_st_next = tg_st_reg + CW'(1);
      fast_next = fast_reg;
      flag_cnt_next = (flag_cnt_reg != '0) ? flag_cnt_reg - CW'(1) : '0;
      unique case (tg_reg)
         ltmc_pkg::LTMC_TG_IDLE: begin
            tg_tot_next = '0;
            tg_st_next = '0;
            if (in_norm && !en_f && txd_f) tg_next = ltmc_pkg::LTMC_TG_HI1;
         end
         ltmc_pkg::LTMC_TG_HI1: begin
            if (!txd_f) begin
               tg_next = step_ok ? ltmc_pkg::LTMC_TG_LO
                                 : ltmc_pkg::LTMC_TG_FAIL;
               tg_st_next = '0;
            end
         end
         ltmc_pkg::LTMC_TG_LO: begin
            if (txd_f) begin
               tg_next = step_ok ? ltmc_pkg::LTMC_TG_HI2
                                 : ltmc_pkg::LTMC_TG_FAIL;
               tg_st_next = '0;
            end
         end
         ltmc_pkg::LTMC_TG_HI2: begin
            if (!txd_f) tg_next = ltmc_pkg::LTMC_TG_FAIL;
            else if (en_rise) begin
               tg_next = ltmc_pkg::LTMC_TG_IDLE;
               if (step_ok &&
                   tg_tot_reg <= CW'(`LTMC_TOGGLE_MAX_CYC)) begin
                  fast_next = !fast_reg;
                  if (!fast_reg) flag_cnt_next = CW'(`LTMC_FLAG_CYC);
               end
            end
         end
         ltmc_pkg::LTMC_TG_FAIL: begin
            if (en_f) tg_next = ltmc_pkg::LTMC_TG_IDLE;
         end
         default: tg_next = ltmc_pkg::LTMC_TG_IDLE;
      endcase
      if (en_f && tg_reg != ltmc_pkg::LTMC_TG_HI2) begin
         tg_next = ltmc_pkg::LTMC_TG_IDLE;
      end
      // Toggle starts in Normal; only Awake and Sleep restore normal slew, PrepSleep keeps it
      if (!in_norm && mode_reg != ltmc_pkg::LTMC_PREP) begin
         fast_next = 1'b0;
         tg_next = ltmc_pkg::LTMC_TG_IDLE;
         flag_cnt_next = '0;
      end
      fd_cnt_next = !in_norm ? '0
                  : (fd_cnt_reg == '1) ? fd_cnt_reg : fd_cnt_reg + CW'(1);
      dom_cnt_next = (txd_f || !in_norm) ? '0
                   : (dom_cnt_reg == '1) ? dom_cnt_reg
                   : dom_cnt_reg + CW'(1);
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tg_reg <= ltmc_pkg::LTMC_TG_IDLE;
         tg_tot_reg <= '0;
         tg_st_reg <= '0;
         fast_reg <= 1'b0;
         flag_cnt_reg <= '0;
         fd_cnt_reg <= '0;
         dom_cnt_reg <= '0;
      end else if (ce_i) begin
         tg_reg <= tg_next;
         tg_tot_reg <= tg_tot_next;
         tg_st_reg <= tg_st_next;
         fast_reg <= fast_next;
         flag_cnt_reg <= flag_cnt_next;
         fd_cnt_reg <= fd_cnt_next;
         dom_cnt_reg <= dom_cnt_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Pin drive
   logic hot, tx_dom;
   ltmc_pkg::ltmc_pins_t pins_reg, pins_next;
   assign hot = flt.bus_drv_hot || flt.inh_drv_hot;
   assign tx_ok = fd_cnt_reg >= CW'(`LTMC_FIRST_DOM_CYC);
   always_comb begin
      tx_dom = in_norm && !txd_f && tx_ok
             && dom_cnt_reg < CW'(TXD_DOM_CYC)
             && !flt.undervolt && !hot;
      pins_next.bus_pull_low = tx_dom;
      pins_next.rx_oe_n = 1'b0;
      if (mode_reg == ltmc_pkg::LTMC_SLEEP) begin
         pins_next.rx_out = 1'b1;
         pins_next.rx_oe_n = 1'b1;
      end else if (hot) begin
         pins_next.rx_out = 1'b1;
      end else if (flag_cnt_reg != '0) begin
         // Flag falls in PrepSleep, before Normal is re-entered
         pins_next.rx_out = 1'b0;
      end else if (!in_norm) begin
         pins_next.rx_out = !wake_ev_reg;
      end else begin
         pins_next.rx_out = bus_f;
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pins_reg <= '{bus_pull_low: 1'b0, rx_out: 1'b0, rx_oe_n: 1'b0};
      end else if (ce_i) begin
         pins_reg <= pins_next;
      end
   end
   assign bus_o = 1'b0;
   assign bus_oe_n_o = !pins_reg.bus_pull_low;
   assign rxd_o = pins_reg.rx_out;
   assign rxd_oe_n_o = pins_reg.rx_oe_n;
   assign regulator_inhibit_out_o = (mode_reg != ltmc_pkg::LTMC_SLEEP)
                                  && !hot;
   assign fast_rate_o = fast_reg;
   assign mode_o = mode_reg;
   ////////////////////////////////////////////////////////////////////////
   // Received bus samples, one per bus level change in Normal mode
   logic fifo_in_ready, ovr_reg, ovr_next, smp;
   assign smp = in_norm && (bus_f != bus_f_reg) && ce_i;
   always_comb begin
      ovr_next = ovr_reg || (smp && !fifo_in_ready);
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) ovr_reg <= 1'b0;
      else if (ce_i) ovr_reg <= ovr_next;
   end
   assign rx_overrun_o = ovr_reg;
   ltmc_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .in_valid_i(smp),
      .in_ready_o(fifo_in_ready),
      .in_data_i(bus_f),
      .out_valid_o(rx_valid_o),
      .out_ready_i(rx_ready_i),
      .out_data_o(rx_data_o)
   );
   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_uv_recessive;
      @(posedge clk_i) disable iff (srst_i) flt.undervolt |=> bus_oe_n_o;
   endproperty
   a_uv_recessive: assert property (p_uv_recessive)
      else $error("Bus driven during undervoltage");
   property p_sleep_quiet;
      @(posedge clk_i) disable iff (srst_i)
         (mode_reg == ltmc_pkg::LTMC_SLEEP) |=> bus_oe_n_o;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet)
      else $error("Bus driven outside Normal");
   property p_first_dom;
      @(posedge clk_i) disable iff (srst_i)
         !bus_oe_n_o |-> $past(fd_cnt_reg) >= CW'(`LTMC_FIRST_DOM_CYC);
   endproperty
   a_first_dom: assert property (p_first_dom)
      else $error("Dominant before first-dominant delay");
   property p_inh_sleep;
      @(posedge clk_i) disable iff (srst_i)
         (mode_reg == ltmc_pkg::LTMC_SLEEP) |-> !regulator_inhibit_out_o;
   endproperty
   a_inh_sleep: assert property (p_inh_sleep)
      else $error("Inhibit on in Sleep");
   property p_hot;
      @(posedge clk_i) disable iff (srst_i)
         hot && ce_i |-> !regulator_inhibit_out_o ##1 bus_oe_n_o;
   endproperty
   a_hot: assert property (p_hot)
      else $error("Overheat response missing");
   property p_dom_to;
      @(posedge clk_i) disable iff (srst_i)
         dom_cnt_reg >= CW'(TXD_DOM_CYC) |=> bus_oe_n_o;
   endproperty
   a_dom_to: assert property (p_dom_to)
      else $error("Dominant timeout not applied");
   property p_rx_hiz;
      @(posedge clk_i) disable iff (srst_i)
         ce_i && mode_reg == ltmc_pkg::LTMC_SLEEP |=> rxd_oe_n_o;
   endproperty
   a_rx_hiz: assert property (p_rx_hiz)
      else $error("Receive pin driven in Sleep");
   property p_fast_clear;
      @(posedge clk_i) disable iff (srst_i)
         ce_i && mode_reg == ltmc_pkg::LTMC_AWAKE |=> !fast_reg;
   endproperty
   a_fast_clear: assert property (p_fast_clear)
      else $error("Fast rate kept outside Normal");
endmodule : ltmc_ctrl

/* File: dv/ltmc_mcu_model.sv */
// Microcontroller model: drives enable and transmit, runs toggles
`timescale 1ns/10ps
module ltmc_mcu_model #(
   parameter int STEP = 520
) (
   // Clock and bench commands
   input wire logic clk_i,
   input wire logic en_req_i,
   input wire logic txd_req_i,
   input wire logic tog_i,
   // Pins toward the transceiver
   output logic en_o,
   output logic txd_o
);
   initial begin
      en_o = 1'b0;
      txd_o = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // Steps a little over the least time; whole run under limit
   always begin
      @(posedge clk_i);
      if (tog_i) begin
         en_o <= 1'b0;
         txd_o <= 1'b1;
         repeat (STEP) @(posedge clk_i);
         txd_o <= 1'b0;
         repeat (STEP) @(posedge clk_i);
         txd_o <= 1'b1;
         repeat (STEP) @(posedge clk_i);
         en_o <= 1'b1;
      end else begin
         en_o <= en_req_i;
         txd_o <= txd_req_i;
      end
   end
endmodule : ltmc_mcu_model

/* File: dv/testbench.sv */
// Self-checking bench for the transceiver mode controller
`timescale 1ns/10ps
module testbench;
   localparam ltmc_pkg::ltmc_mode_t M_AWK = ltmc_pkg::LTMC_AWAKE;
   localparam ltmc_pkg::ltmc_mode_t M_NRM = ltmc_pkg::LTMC_NORMAL;
   localparam ltmc_pkg::ltmc_mode_t M_PRP = ltmc_pkg::LTMC_PREP;
   localparam ltmc_pkg::ltmc_mode_t M_SLP = ltmc_pkg::LTMC_SLEEP;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic en_req = 1'b0;
   logic txd_req = 1'b1;
   logic tog = 1'b0;
   logic txd_conn = 1'b1;
   logic wake = 1'b0;
   logic bus_ext = 1'b1;
   logic rx_ready = 1'b1;
   ltmc_pkg::ltmc_fault_t fault = 3'h0;
   logic en, txd, bus_i, rxd_o, rxd_oe_n_o, bus_o, bus_oe_n_o, bad;
   logic inh_o, fast_rate_o, rx_valid_o, rx_data_o, rx_overrun_o;
   ltmc_pkg::ltmc_mode_t mode_o;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;

   always #12.5 clk_i = ~clk_i;
   // Open drain: either party may pull the wire low
   assign bus_i = (bus_oe_n_o ? 1'b1 : bus_o) & bus_ext;

   ltmc_mcu_model u_mcu (.clk_i(clk_i), .en_req_i(en_req),
      .txd_req_i(txd_req), .tog_i(tog), .en_o(en), .txd_o(txd));
   ltmc_ctrl #(.TXD_DOM_CYC(200), .FIFO_DEPTH(32)) u_dut (
      .clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .txd_i(txd),
      .txd_conn_i(txd_conn), .en_i(en), .rxd_o(rxd_o),
      .rxd_oe_n_o(rxd_oe_n_o), .bus_i(bus_i), .bus_o(bus_o),
      .bus_oe_n_o(bus_oe_n_o), .wake_i(wake), .fault_i(fault),
      .regulator_inhibit_out_o(inh_o), .fast_rate_o(fast_rate_o),
      .mode_o(mode_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready),
      .rx_data_o(rx_data_o), .rx_overrun_o(rx_overrun_o));

   ////////////////////////////////////////////////////////////
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask : cyc

   task automatic check(input logic [1:0] got, input logic [1:0] exp,
         input string msg);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic wait_mode(input logic [1:0] m, input int lim);
      int k;
      k = 0;
      while (mode_o !== m && k < lim) begin
         @(posedge clk_i);
         k++;
      end
      check(mode_o, m, "mode");
   endtask : wait_mode

   task automatic to_normal();
      en_req <= 1'b1;
      wait_mode(M_NRM, 450);
   endtask : to_normal

   task automatic toggle();
      tog <= 1'b1;
      cyc(1);
      tog <= 1'b0;
      wait (en === 1'b0);
      wait (en === 1'b1);
   endtask : toggle

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   task automatic s_entry();
      check(mode_o, M_AWK, "reset mode");
      check(rxd_o, 1'b0, "reset rx");
      check(inh_o, 1'b1, "reset inhibit");
      en_req <= 1'b1;
      cyc(200);
      en_req <= 1'b0;
      cyc(20);
      check(mode_o, M_AWK, "short enable");
      to_normal();
      txd_req <= 1'b0;
      bus_ext <= 1'b0;
      cyc(10);
      check(rxd_o, 1'b0, "rx at entry");
      bus_ext <= 1'b1;
      cyc(90);
      check(bus_oe_n_o, 1'b1, "early dominant");
      check(rxd_o, 1'b1, "rx recessive");
      txd_req <= 1'b1;
      cyc(2000);
      txd_req <= 1'b0;
      cyc(10);
      check(bus_oe_n_o, 1'b0, "dominant");
      check(rxd_o, 1'b0, "rx echo");
      cyc(100);
      check(bus_oe_n_o, 1'b0, "still dominant");
      cyc(110);
      check(bus_oe_n_o, 1'b1, "dominant timeout");
      bus_ext <= 1'b0;
      cyc(10);
      check(rxd_o, 1'b0, "rx after timeout");
      bus_ext <= 1'b1;
      txd_req <= 1'b1;
      cyc(10);
      check(bus_oe_n_o, 1'b1, "release");
   endtask : s_entry

   task automatic s_faults();
      for (int i = 0; i < 3; i++) begin
         fault <= 3'h1 << i;
         bus_ext <= 1'b0;
         txd_req <= 1'b0;
         cyc(20);
         check(bus_oe_n_o, 1'b1, "fault tx");
         if (i < 2) begin
            check(inh_o, 1'b0, "hot inhibit");
            check(rxd_o, 1'b1, "hot rx");
         end
         fault <= 3'h0;
         bus_ext <= 1'b1;
         txd_req <= 1'b1;
         cyc(20);
         check(inh_o, 1'b1, "recovered");
      end
      txd_conn <= 1'b0;
      txd_req <= 1'b0;
      cyc(20);
      check(bus_oe_n_o, 1'b1, "floating tx");
      txd_conn <= 1'b1;
      txd_req <= 1'b1;
   endtask : s_faults

   task automatic s_fifo();
      rx_ready <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         bus_ext <= i[0];
         cyc(8);
      end
      check(rx_overrun_o, 1'b1, "overrun");
      rx_ready <= 1'b1;
      n = 0;
      repeat (40) begin
         @(posedge clk_i);
         if (rx_valid_o === 1'b1) begin
            check(rx_data_o, n[0], "fifo data");
            n++;
         end
      end
      check(n == 32, 1'b1, "fifo depth");
   endtask : s_fifo

   task automatic s_toggle();
      toggle();
      cyc(70);
      check(rxd_o, 1'b0, "entry flag");
      wait_mode(M_NRM, 500);
      check(rxd_o, 1'b1, "flag over");
      check(fast_rate_o, 1'b1, "fast on");
      toggle();
      bad = 1'b0;
      repeat (250) begin
         @(posedge clk_i);
         if (rxd_o !== 1'b1) bad = 1'b1;
      end
      check(bad, 1'b0, "exit high");
      wait_mode(M_NRM, 500);
      check(fast_rate_o, 1'b0, "fast off");
      toggle();
      wait_mode(M_NRM, 500);
   endtask : s_toggle

   task automatic s_sleep();
      en_req <= 1'b0;
      cyc(2600);
      check(mode_o, M_PRP, "sleep delay");
      wait_mode(M_SLP, 400);
      // Registered pins settle one edge after the mode
      cyc(2);
      check(fast_rate_o, 1'b0, "fast cleared");
      check(inh_o, 1'b0, "inhibit off");
      check(rxd_oe_n_o, 1'b1, "rx released");
      txd_req <= 1'b0;
      cyc(20);
      check(bus_oe_n_o, 1'b1, "sleep tx");
      txd_req <= 1'b1;
      wake <= 1'b1;
      cyc(500);
      wake <= 1'b0;
      cyc(2000);
      check(mode_o, M_SLP, "wake glitch");
      wake <= 1'b1;
      wait_mode(M_AWK, 2000);
      cyc(2);
      check(rxd_o, 1'b0, "wake report");
      check(rxd_oe_n_o, 1'b0, "report drive");
      check(inh_o, 1'b1, "inhibit on");
      to_normal();
      en_req <= 1'b0;
      cyc(200);
      wake <= 1'b0;
      cyc(3300);
      check(mode_o, M_AWK, "wake in delay");
      to_normal();
      en_req <= 1'b0;
      wait_mode(M_SLP, 3000);
      bus_ext <= 1'b0;
      cyc(1000);
      bus_ext <= 1'b1;
      cyc(50);
      check(mode_o, M_SLP, "short bus pulse");
      bus_ext <= 1'b0;
      cyc(3000);
      check(mode_o, M_SLP, "bus held low");
      bus_ext <= 1'b1;
      cyc(50);
      check(mode_o, M_AWK, "bus wake");
   endtask : s_sleep

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         $display("CHECK FAILED at %0t: run too long", $time);
         complete_run();
      end
   end

   initial begin
      cyc(6);
      srst_i <= 1'b0;
      cyc(2);
      s_entry();
      s_faults();
      s_fifo();
      s_toggle();
      s_sleep();
      complete_run();
   end
endmodule : testbench
